// file: src/interp_regs.svh
`ifndef INTERP_REGS_SVH
`define INTERP_REGS_SVH
// How it works
// - Inbound frame: header, up to 64 script words, checksum; counted in bytes.
// - Reply: header, up to 496 results, two status words, checksum; overflow 103.
// - Header word holds the byte count of the whole frame.
// - Checksum is XOR of all earlier words; inbound mismatch gives 201.
// - One result word per value-returning command, in execution order.
// - Status is error code then description; code 0 means success.
// - Bits 15:14 give the class: 00 digital, 01 analog, 11 misc.
// - Bits 13:8 select, bits 7:0 operand; unknown command gives 101.
// - Whole script is received, then run, then the reply is sent.
// - 1C-1E read sensor registers; 2C-2E write them, returning old data.
// - 01 sets conversion-start line; 02 waits for data ready; no result.
// - C1 picks digital or analog mode; class mismatch gives 102.
// - One loop level: C2 starts with count operand, C3 ends.
// - Nested loop gives 104, other loop faults 105, with command number.
// - Script longer than supported gives 202 with the script length.
// - No data from host gives 203; bad transmission gives 204.
// - C4 returns the version in BCD, major high byte, minor low.
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_ERR 8'h08
`define A_IST 8'h0C
`define A_IMSK 8'h10
`define A_VER 8'h14
`define CTRL_EN_RST 1'b1
`define IMSK_RST 2'h0
`define SCRIPT_MAX 16'h0040
`define RES_MAX 9'h1F0
`define E_SYN 16'h0065
`define E_MODE 16'h0066
`define E_MEM 16'h0067
`define E_NEST 16'h0068
`define E_LOOP 16'h0069
`define E_CRC 16'h00C9
`define E_LEN 16'h00CA
`define E_NODATA 16'h00CB
`define E_XMIT 16'h00CC
`define E_ADC 16'h012D
`define CL_ANA 2'h1
`define CL_BAD 2'h2
`define CL_MISC 2'h3
`define T_INIT 8'h01
`define T_DRW 8'h02
`define T_RD0 8'h1C
`define T_RD1 8'h1D
`define T_RD2 8'h1E
`define T_WR0 8'h2C
`define T_WR1 8'h2D
`define T_WR2 8'h2E
`define T_ADX 8'h41
`define T_ADY 8'h42
`define T_ADZ 8'h43
`define T_ADT 8'h44
`define T_CTL 8'h45
`define T_MODE 8'hC1
`define T_LS 8'hC2
`define T_LE 8'hC3
`define T_VER 8'hC4
`define CLK_MHZ 125
`define DR_TMO_US 1000
`define GAP_TMO_US 10000
`endif

// file: src/interp_pkg.sv
package interp_pkg;

typedef enum logic [3:0] {
    S_IDLE, S_RXB, S_RXC, S_DRN, S_EX, S_SRW, S_ADW, S_DRW, S_TX
} fsm_t;

typedef struct packed {
    logic range_extend_line;
    logic bias_invert_line;
    logic low_power_line;
    logic [1:0] axis_select;
    logic [1:0] range_select;
} ctl_lines_t;

typedef struct packed {
    fsm_t fsm;
    logic rx_rdy;
    logic tx_vld;
    logic [15:0] tx_dat;
    logic sreq;
    logic swr;
    logic [1:0] sadr;
    logic [7:0] swd;
    logic areq;
    logic [1:0] ach;
    logic conv;
    logic ana;
    ctl_lines_t ctl;
    logic dr_m;
    logic dr_s;
    logic [6:0] slen;
    logic [15:0] rcnt;
    logic [15:0] xr;
    logic [6:0] pc;
    logic [8:0] nres;
    logic inl;
    logic [6:0] lst;
    logic [7:0] lcnt;
    logic [23:0] tmr;
    logic [15:0] ecode;
    logic [15:0] edesc;
    logic [8:0] tidx;
    logic [31:0] pdat;
    logic prdy;
    logic perr;
    logic en;
    logic [1:0] ist;
    logic [1:0] imsk;
    logic irq;
} st_t;

endpackage

// file: src/sensor_script_interpreter.sv
`timescale 1ns/1ns
`include "interp_regs.svh"
module sensor_script_interpreter
    import interp_pkg::*;
#(
    parameter int unsigned DR_TMO_CYC = `DR_TMO_US * `CLK_MHZ,
    parameter int unsigned GAP_TMO_CYC = `GAP_TMO_US * `CLK_MHZ,
    // Arbitrary value.
    parameter logic [15:0] VERSION_BCD = 16'h0100
) (
    input wire logic clk, // 125 MHz clock
    input wire logic rst_n, // synchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic irq, // interrupt level
    input wire logic rx_valid, // host word valid
    input wire logic [15:0] rx_data, // host word
    output logic rx_ready, // host word taken
    output logic tx_valid, // reply word valid
    output logic [15:0] tx_data, // reply word
    input wire logic tx_ready, // reply word taken
    output logic sreg_req, // sensor register request
    output logic sreg_wr, // sensor register write
    output logic [1:0] sreg_addr, // sensor register number
    output logic [7:0] sreg_wdata, // sensor register value
    input wire logic sreg_ack, // sensor access done
    input wire logic [15:0] sreg_rdata, // returned data
    output logic adc_req, // digitize request
    output logic [1:0] adc_chan, // x, y, z, temperature
    input wire logic adc_ack, // sample ready
    input wire logic [15:0] adc_data, // sample
    input wire logic data_ready_line, // sensor data ready pin
    output logic conv_start_line, // conversion start pin
    output logic analog_mode, // high in analog mode
    output ctl_lines_t sensor_ctl // analog control lines
);

st_t s;
st_t n;
logic [15:0] smem [0:`SCRIPT_MAX-1];
logic [15:0] rmem [0:`RES_MAX-1];
logic acc;
logic go_tx;
logic err;
logic push;
logic swe;
logic rwe;
logic [15:0] ec;
logic [15:0] ed;
logic [15:0] pv;
logic [15:0] w;
logic [15:0] sl;
logic [15:0] pcw;
logic [15:0] nw;
logic [15:0] hdr;
logic [1:0] ev;
logic [1:0] clr;

function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `A_CTRL) || (a == `A_STAT) || (a == `A_ERR) ||
        (a == `A_IST) || (a == `A_IMSK) || (a == `A_VER);
endfunction

always_comb begin
    n = s;
    go_tx = 1'b0;
    err = 1'b0;
    push = 1'b0;
    swe = 1'b0;
    rwe = 1'b0;
    ec = 16'h0000;
    ed = 16'h0000;
    pv = 16'h0000;
    nw = 16'h0000;
    ev = 2'h0;
    clr = 2'h0;
    acc = rx_valid & s.rx_rdy;
    w = smem[s.pc[5:0]];
    pcw = {9'h000, s.pc};
    sl = {1'b0, rx_data[15:1]} - 16'h0002;
    n.dr_m = data_ready_line;
    n.dr_s = s.dr_m;

    // Registers answer one cycle into the access phase.
    n.prdy = 1'b0;
    n.perr = 1'b0;
    if (psel && penable && !s.prdy) begin
        n.prdy = 1'b1;
        n.perr = !mapped(paddr);
        case (paddr)
            `A_CTRL: n.pdat = {31'h0000_0000, s.en};
            `A_STAT: n.pdat = {s.fsm != S_IDLE, s.ana, s.inl, 20'h0_0000,
                s.nres};
            `A_ERR: n.pdat = {s.edesc, s.ecode};
            `A_IST: n.pdat = {30'h0000_0000, s.ist};
            `A_IMSK: n.pdat = {30'h0000_0000, s.imsk};
            `A_VER: n.pdat = {16'h0000, VERSION_BCD};
            default: n.pdat = 32'h0000_0000;
        endcase
    end
    if (psel && penable && s.prdy && pwrite && mapped(paddr)) begin
        case (paddr)
            `A_CTRL: n.en = pwdata[0];
            `A_IST: clr = pwdata[1:0];
            `A_IMSK: n.imsk = pwdata[1:0];
            default: ;
        endcase
    end

    case (s.fsm)
        S_IDLE: begin
            if (acc) begin
                n.xr = rx_data;
                n.pc = 7'h00;
                n.nres = 9'h000;
                n.inl = 1'b0;
                n.tmr = 24'h00_0000;
                n.ecode = 16'h0000;
                n.edesc = 16'h0000;
                n.slen = 7'h00;
                if (rx_data[0] || rx_data < 16'h0004) begin
                    err = 1'b1;
                    ec = `E_XMIT;
                end else if (sl > `SCRIPT_MAX) begin
                    // The rest of the frame is still swallowed.
                    n.ecode = `E_LEN;
                    n.edesc = sl;
                    n.rcnt = sl + 16'h0001;
                    n.fsm = S_DRN;
                end else begin
                    n.slen = sl[6:0];
                    n.fsm = (sl == 16'h0000) ? S_RXC : S_RXB;
                end
            end
        end
        S_RXB, S_RXC, S_DRN: begin
            n.tmr = s.tmr + 24'h00_0001;
            if (acc) begin
                n.tmr = 24'h00_0000;
                n.xr = s.xr ^ rx_data;
                if (s.fsm == S_RXB) begin
                    swe = 1'b1;
                    n.pc = s.pc + 7'h01;
                    if (s.pc + 7'h01 == s.slen) begin
                        n.fsm = S_RXC;
                    end
                end else if (s.fsm == S_RXC) begin
                    if (rx_data != s.xr) begin
                        err = 1'b1;
                        ec = `E_CRC;
                    end else begin
                        n.pc = 7'h00;
                        n.fsm = S_EX;
                    end
                end else begin
                    n.rcnt = s.rcnt - 16'h0001;
                    if (s.rcnt == 16'h0001) begin
                        go_tx = 1'b1;
                    end
                end
            end else if (s.tmr == 24'(GAP_TMO_CYC)) begin
                err = 1'b1;
                ec = `E_NODATA;
            end
        end
        S_EX: begin
            n.tmr = 24'h00_0000;
            if (s.pc == s.slen) begin
                if (s.inl) begin
                    err = 1'b1;
                    ec = `E_LOOP;
                    ed = pcw;
                end else begin
                    go_tx = 1'b1;
                end
            end else if (w[15:14] == `CL_BAD) begin
                err = 1'b1;
                ec = `E_SYN;
                ed = pcw;
            end else if (w[15:14] != `CL_MISC &&
                s.ana != (w[15:14] == `CL_ANA)) begin
                err = 1'b1;
                ec = `E_MODE;
                ed = pcw;
            end else begin
                case (w[15:8])
                    `T_RD0, `T_RD1, `T_RD2,
                    `T_WR0, `T_WR1, `T_WR2: begin
                        n.sreq = 1'b1;
                        n.swr = w[13];
                        n.sadr = w[9:8];
                        n.swd = w[7:0];
                        n.fsm = S_SRW;
                    end
                    `T_INIT: begin
                        n.conv = w[0];
                        n.pc = s.pc + 7'h01;
                    end
                    `T_DRW: begin
                        n.fsm = S_DRW;
                    end
                    `T_ADX, `T_ADY, `T_ADZ, `T_ADT: begin
                        n.areq = 1'b1;
                        n.ach = 2'(w[9:8] - 2'h1);
                        n.fsm = S_ADW;
                    end
                    `T_CTL: begin
                        n.ctl = w[6:0];
                        n.pc = s.pc + 7'h01;
                    end
                    `T_MODE: begin
                        n.ana = w[0];
                        n.pc = s.pc + 7'h01;
                    end
                    `T_LS: begin
                        if (s.inl) begin
                            err = 1'b1;
                            ec = `E_NEST;
                            ed = pcw;
                        end else if (w[7:0] == 8'h00) begin
                            err = 1'b1;
                            ec = `E_LOOP;
                            ed = pcw;
                        end else begin
                            n.inl = 1'b1;
                            n.lst = s.pc;
                            n.lcnt = w[7:0];
                            n.pc = s.pc + 7'h01;
                        end
                    end
                    `T_LE: begin
                        if (!s.inl) begin
                            err = 1'b1;
                            ec = `E_LOOP;
                            ed = pcw;
                        end else if (s.lcnt > 8'h01) begin
                            n.lcnt = s.lcnt - 8'h01;
                            n.pc = s.lst + 7'h01;
                        end else begin
                            n.inl = 1'b0;
                            n.pc = s.pc + 7'h01;
                        end
                    end
                    `T_VER: begin
                        push = 1'b1;
                        pv = VERSION_BCD;
                    end
                    default: begin
                        err = 1'b1;
                        ec = `E_SYN;
                        ed = pcw;
                    end
                endcase
            end
        end
        S_SRW: begin
            if (sreg_ack) begin
                n.sreq = 1'b0;
                push = 1'b1;
                pv = sreg_rdata;
            end
        end
        S_ADW, S_DRW: begin
            n.tmr = s.tmr + 24'h00_0001;
            if (s.fsm == S_ADW && adc_ack) begin
                n.areq = 1'b0;
                push = 1'b1;
                pv = adc_data;
            end else if (s.fsm == S_DRW && s.dr_s) begin
                n.pc = s.pc + 7'h01;
                n.fsm = S_EX;
            end else if (s.tmr == 24'(DR_TMO_CYC)) begin
                err = 1'b1;
                ec = `E_ADC;
                ed = pcw;
            end
        end
        S_TX: begin
            if (tx_ready) begin
                n.tidx = s.tidx + 9'h001;
                if (s.tidx == s.nres + 9'h003) begin
                    n.tx_vld = 1'b0;
                    n.fsm = S_IDLE;
                    ev = {s.ecode != 16'h0000, 1'b1};
                end else begin
                    if (s.tidx < s.nres) begin
                        nw = rmem[s.tidx];
                    end else if (s.tidx == s.nres) begin
                        nw = s.ecode;
                    end else if (s.tidx == s.nres + 9'h001) begin
                        nw = s.edesc;
                    end else begin
                        nw = s.xr;
                    end
                    n.tx_dat = nw;
                    n.xr = s.xr ^ nw;
                end
            end
        end
        default: n.fsm = S_IDLE;
    endcase

    if (push) begin
        if (s.nres == `RES_MAX) begin
            err = 1'b1;
            ec = `E_MEM;
            ed = pcw;
        end else begin
            rwe = 1'b1;
            n.nres = s.nres + 9'h001;
            n.pc = s.pc + 7'h01;
            n.fsm = S_EX;
        end
    end
    if (err) begin
        n.ecode = ec;
        n.edesc = ed;
        go_tx = 1'b1;
    end
    hdr = {6'h00, 9'(n.nres + 9'h004), 1'b0};
    if (go_tx) begin
        n.fsm = S_TX;
        n.tidx = 9'h000;
        n.xr = hdr;
        n.tx_vld = 1'b1;
        n.tx_dat = hdr;
        n.sreq = 1'b0;
        n.areq = 1'b0;
    end
    n.rx_rdy = s.en && (n.fsm == S_IDLE || n.fsm == S_RXB ||
        n.fsm == S_RXC || n.fsm == S_DRN);
    // A new event wins over a clear in the same cycle.
    n.ist = (s.ist & ~clr) | ev;
    n.irq = |(n.ist & n.imsk);
end

always_ff @(posedge clk) begin
    if (!rst_n) begin
        s <= '0;
        s.en <= `CTRL_EN_RST;
        s.imsk <= `IMSK_RST;
    end else begin
        s <= n;
    end
end

// Memories carry no reset; only words below the counters are ever read.
always_ff @(posedge clk) begin
    if (swe) begin
        smem[s.pc[5:0]] <= rx_data;
    end
    if (rwe) begin
        rmem[s.nres] <= pv;
    end
end

assign prdata = s.pdat;
assign pready = s.prdy;
assign pslverr = s.perr;
assign irq = s.irq;
assign rx_ready = s.rx_rdy;
assign tx_valid = s.tx_vld;
assign tx_data = s.tx_dat;
assign sreg_req = s.sreq;
assign sreg_wr = s.swr;
assign sreg_addr = s.sadr;
assign sreg_wdata = s.swd;
assign adc_req = s.areq;
assign adc_chan = s.ach;
assign conv_start_line = s.conv;
assign analog_mode = s.ana;
assign sensor_ctl = s.ctl;

endmodule

// file: dv/sensor_script_interpreter_chk.sv
`timescale 1ns/1ns
module sensor_script_interpreter_chk (
    input logic clk, // clock
    input logic rst_n, // synchronous reset
    input logic psel, // select
    input logic penable, // enable
    input logic pready, // ready
    input logic pslverr, // error
    input logic rx_ready, // host word taken
    input logic tx_valid, // reply word valid
    input logic [15:0] tx_data, // reply word
    input logic tx_ready, // reply word taken
    input logic sreg_req, // register request
    input logic sreg_wr, // register write
    input logic [1:0] sreg_addr, // register number
    input logic sreg_ack, // register done
    input logic adc_req, // digitize request
    input logic [1:0] adc_chan, // channel
    input logic adc_ack, // sample ready
    input logic analog_mode // analog mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_wait;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait) else $error("bad wait state");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply dropped");
    property p_no_rx;
        tx_valid |-> !rx_ready;
    endproperty
    a_no_rx: assert property (p_no_rx) else $error("rx during reply");
    property p_sreg_hold;
        sreg_req && !sreg_ack |=> sreg_req && $stable({sreg_wr, sreg_addr});
    endproperty
    a_sreg_hold: assert property (p_sreg_hold) else $error("req moved");
    property p_sreg_drop;
        sreg_req && sreg_ack |=> !sreg_req;
    endproperty
    a_sreg_drop: assert property (p_sreg_drop) else $error("req stays");
    property p_sreg_addr;
        sreg_req |-> sreg_addr != 2'h3;
    endproperty
    a_sreg_addr: assert property (p_sreg_addr) else $error("bad reg");
    property p_dig_mode;
        sreg_req |-> !analog_mode && !adc_req;
    endproperty
    a_dig_mode: assert property (p_dig_mode) else $error("mode clash");
    property p_ana_mode;
        adc_req |-> analog_mode;
    endproperty
    a_ana_mode: assert property (p_ana_mode) else $error("adc in digital");
    property p_adc_hold;
        adc_req && $past(adc_req) |-> $stable(adc_chan);
    endproperty
    a_adc_hold: assert property (p_adc_hold) else $error("chan moved");
    c_wr: cover property (sreg_req && sreg_wr && sreg_ack);
    c_adc: cover property (adc_req && adc_ack);
    c_err: cover property (pslverr);
    c_reply: cover property ($fell(tx_valid));
endmodule
bind sensor_script_interpreter sensor_script_interpreter_chk u_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .sreg_req(sreg_req), .sreg_wr(sreg_wr), .sreg_addr(sreg_addr),
    .sreg_ack(sreg_ack), .adc_req(adc_req), .adc_chan(adc_chan),
    .adc_ack(adc_ack), .analog_mode(analog_mode));

// file: dv/host_link_model.sv
`timescale 1ns/1ns
module host_link_model (
    input wire logic clk, // clock
    input wire logic slow, // sink ready every other cycle
    output logic rx_valid, // word offered
    output logic [15:0] rx_data, // offered word
    input wire logic rx_ready, // word taken
    input wire logic tx_valid, // reply word valid
    input wire logic [15:0] tx_data, // reply word
    output logic tx_ready // sink ready
);
    logic [15:0] reply[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 16'h0000;
        tx_ready = 1'b0;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            reply.push_back(tx_data);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    // Each word is held up to the edge at which it is taken.
    task automatic put(input logic [15:0] w);
        rx_valid <= 1'b1;
        rx_data <= w;
        do @(posedge clk); while (rx_ready !== 1'b1);
    endtask
    // A released line shows the inverse of its last word, never a copy.
    task automatic stop;
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask
    task automatic send(input logic [15:0] s[$], input logic [15:0] flip);
        logic [15:0] x;
        x = 16'((s.size() + 2) * 2);
        @(posedge clk);
        put(x);
        foreach (s[i]) begin
            put(s[i]);
            x ^= s[i];
        end
        put(x ^ flip);
        stop();
    endtask
endmodule

// file: dv/sensor_script_interpreter_test.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module sensor_script_interpreter_test;
    localparam logic [15:0] VER = 16'h0102;
    localparam logic [15:0] OK = 16'h0000;
    logic clk, rst_n, psel, penable, pwrite, sreg_ack, adc_ack, dr, slow;
    logic pready, pslverr, irq, rx_valid, rx_ready, er;
    logic tx_valid, tx_ready, sreg_req, sreg_wr, adc_req, conv, amode;
    logic [7:0] paddr, sreg_wdata;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] rx_data, tx_data, sreg_rdata, adc_data, q[$], r[$];
    logic [1:0] sreg_addr, adc_chan;
    logic [6:0] ctl;
    int errors = 0, check_count = 0;
    sensor_script_interpreter #(.DR_TMO_CYC(40), .GAP_TMO_CYC(60),
        .VERSION_BCD(VER)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .sreg_req(sreg_req), .sreg_wr(sreg_wr), .sreg_addr(sreg_addr),
        .sreg_wdata(sreg_wdata), .sreg_ack(sreg_ack),
        .sreg_rdata(sreg_rdata), .adc_req(adc_req), .adc_chan(adc_chan),
        .adc_ack(adc_ack), .adc_data(adc_data), .data_ready_line(dr),
        .conv_start_line(conv), .analog_mode(amode), .sensor_ctl(ctl));
    host_link_model host (.clk(clk), .slow(slow), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    // The sensor answers a cycle late and shows inverted data otherwise,
    // so a capture on the wrong edge cannot pass.
    always @(posedge clk) begin
        sreg_ack <= sreg_req && !sreg_ack;
        sreg_rdata <= sreg_req ? {4'h5, 2'h0, sreg_addr, sreg_wdata}
            : ~sreg_rdata;
        adc_ack <= adc_req && !adc_ack;
        adc_data <= adc_req ? {8'hAD, 6'h00, adc_chan} : ~adc_data;
        dr <= conv;
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ready, data and error are taken at the edge that sees ready high.
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    task automatic expect_reply(input logic [15:0] e[$],
        input logic [15:0] c, input logic [15:0] d);
        logic [15:0] x;
        int t;
        x = 16'h0000;
        e.push_front(16'((e.size() + 4) * 2));
        e.push_back(c);
        e.push_back(d);
        foreach (e[i]) x ^= e[i];
        e.push_back(x);
        for (t = 0; t < 20000 && host.reply.size() < e.size(); t++)
            @(posedge clk);
        `CHK(host.reply.size(), e.size())
        foreach (e[i]) `CHK(host.reply[i], e[i])
        host.reply.delete();
    endtask
    task automatic run(input logic [15:0] s[$], input logic [15:0] e[$],
        input logic [15:0] c, input logic [15:0] d);
        host.send(s, 16'h0000);
        expect_reply(e, c, d);
    endtask
    initial begin
        #400000;
        errors++;
        conclude();
    end
    initial begin
        rst_n <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
        slow <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h14, 32'h0000_0000);
        `CHK(rd, {16'h0000, VER})
        apb(1'b0, 8'h00, 32'h0000_0000);
        `CHK(rd[0], 1'b1)
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK({er, rd}, 33'h1_0000_0000)
        apb(1'b1, 8'h00, 32'h0000_0000);
        apb(1'b0, 8'h00, 32'h0000_0000);
        `CHK({rx_ready, rd[0]}, 2'b00)
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h10, 32'h0000_0003);
        run('{16'hC400}, '{VER}, OK, OK);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        `CHK({irq, rd}, 33'h1_0000_0001)
        apb(1'b1, 8'h0C, 32'h0000_0001);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        `CHK({irq, rd}, 33'h0_0000_0000)
        q = '{16'hC100, 16'h1C00, 16'h1D00, 16'h1E00, 16'h2C55, 16'h2D12,
            16'h2EAA, 16'h0101, 16'h0200, 16'h0100};
        r = '{16'h5000, 16'h5100, 16'h5200, 16'h5055, 16'h5112, 16'h52AA};
        slow <= 1'b1;
        run(q, r, OK, OK);
        `CHK(conv, 1'b0)
        q = '{16'hC101, 16'h4100, 16'h4200, 16'h4300, 16'h4400, 16'h4555};
        run(q, '{16'hAD00, 16'hAD01, 16'hAD02, 16'hAD03}, OK, OK);
        `CHK({amode, ctl}, 8'hD5)
        slow <= 1'b0;
        run('{16'hC100, 16'h4100}, '{}, 16'h0066, 16'h0001);
        run('{16'hC101, 16'h1C00}, '{}, 16'h0066, 16'h0001);
        run('{16'hC100, 16'h3F00}, '{}, 16'h0065, 16'h0001);
        run('{16'h8000}, '{}, 16'h0065, 16'h0000);
        run('{16'hC202, 16'hC202}, '{}, 16'h0068, 16'h0001);
        run('{16'hC300}, '{}, 16'h0069, 16'h0000);
        q = '{16'hC203, 16'h1D00, 16'hC300, 16'hC400};
        run(q, '{16'h5100, 16'h5100, 16'h5100, VER}, OK, OK);
        apb(1'b0, 8'h04, 32'h0000_0000);
        `CHK(rd, 32'h0000_0004)
        run('{16'hC100, 16'h0100, 16'h0200}, '{}, 16'h012D, 16'h0002);
        apb(1'b0, 8'h08, 32'h0000_0000);
        `CHK(rd, 32'h0002_012D)
        apb(1'b0, 8'h0C, 32'h0000_0000);
        `CHK(rd, 32'h0000_0003)
        host.send('{16'hC400}, 16'h0001);
        expect_reply('{}, 16'h00C9, OK);
        q.delete();
        r.delete();
        repeat (64) begin
            q.push_back(16'hC400);
            r.push_back(VER);
        end
        run(q, r, OK, OK);
        q.push_back(16'hC400);
        run(q, '{}, 16'h00CA, 16'h0041);
        host.put(16'h0005);
        host.stop();
        expect_reply('{}, 16'h00CC, OK);
        host.put(16'h0006);
        host.stop();
        expect_reply('{}, 16'h00CB, OK);
        q = '{16'hC2FF, 16'h1C00, 16'hC400, 16'hC300};
        r.delete();
        repeat (248) begin
            r.push_back(16'h5000);
            r.push_back(VER);
        end
        run(q, r, 16'h0067, 16'h0001);
        conclude();
    end
endmodule
